// ===== hw/rpmco_top.sv
`timescale 1ns/1ns
`include "rpmco_defs.svh"
module rpmco_top
  import rpmco_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hardware_reset_in_n,
  input wire logic input_clock_buffer,
  input wire rpmco_clks_s clks,
  input wire logic [2:0] clkout_sel,
  input wire logic [7:0] outclk_div,
  input wire logic sw_sys_reset_req,
  input wire logic sw_core_reset_req,
  input wire logic sec_reset_req,
  input wire logic tru_reset_req,
  input wire logic emu_reset_req,
  input wire logic pll_locked,
  input wire logic deep_sleep_req,
  input wire logic hibernate_req,
  input wire logic wake_event,
  output logic clock_output_pin,
  output logic regulator_wake_out,
  output logic system_reset_out,
  output logic core_reset_out,
  output logic pins_tristate,
  output rpmco_pwr_s pwr,
  output rpmco_mode_e mode
);
  // =====================================================
  // input synchronisers
  // =====================================================
  // pins and foreign clocks pass two flops; the first stage feeds only the second
  logic [9:0] sync_a;
  logic [9:0] sync_b;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_a <= 10'h000;
      sync_b <= 10'h000;
    end else begin
      sync_a <= {~hardware_reset_in_n, input_clock_buffer, clks.core, clks.sys, clks.periph,
                 clks.crypto, clks.dram, clks.outclk, pll_locked, wake_event};
      sync_b <= sync_a;
    end
  end
  logic hw_rst_s;
  logic buf_s;
  logic pll_locked_s;
  logic wake_s;
  logic [5:0] clk_lv;
  assign hw_rst_s = sync_b[9];
  assign buf_s = sync_b[8];
  assign clk_lv = sync_b[7:2];
  assign pll_locked_s = sync_b[1];
  assign wake_s = sync_b[0];

  // =====================================================
  // hardware reset: local reset term
  // =====================================================
  // hardware reset input low clears this controller, except the hibernate wake trigger hib_from_reset, which it sets when the mode is hibernate
  logic hw_clr;
  assign hw_clr = !rst_b || hw_rst_s;

  // =====================================================
  // power mode
  // =====================================================
  logic sys_rst_pend;
  rpmco_rst_e rst_state;
  rpmco_rst_e next_rst_state;
  logic [3:0] rst_cnt;
  logic pll_was_locked;
  logic hib_from_reset;

  always_ff @(posedge clk) begin
    if (hw_clr) begin
      mode <= RPMCO_FULL_ON;
    end else begin
      unique case (mode)
        RPMCO_FULL_ON: begin
          if (hibernate_req) begin
            mode <= RPMCO_HIBERNATE;
          end else if (deep_sleep_req) begin
            mode <= RPMCO_DEEP_SLEEP;
          end
        end
        RPMCO_DEEP_SLEEP: begin
          if (wake_s) begin
            mode <= RPMCO_FULL_ON;
          end
        end
        RPMCO_HIBERNATE: begin
          mode <= RPMCO_HIBERNATE;
        end
        default: begin
          mode <= RPMCO_FULL_ON;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (hw_clr) begin
      pwr <= '{pll_en: 1'b1, pll_bypass: 1'b0, core_clk_en: 1'b1, sync_clk_en: 1'b1,
               async_block: 1'b0, core_pwr: 1'b1};
    end else begin
      pwr.pll_en <= (mode == RPMCO_FULL_ON);
      pwr.pll_bypass <= 1'b0;
      pwr.core_clk_en <= (mode == RPMCO_FULL_ON) && (rst_state != RPMCO_CORE_RST);
      pwr.sync_clk_en <= (mode == RPMCO_FULL_ON);
      pwr.async_block <= (mode != RPMCO_FULL_ON);
      pwr.core_pwr <= (mode != RPMCO_HIBERNATE);
    end
  end

  // =====================================================
  // reset controller
  // =====================================================
  // a hibernate entry also asks for a system reset so the wake path boots clean
  logic sys_req;
  assign sys_req = sw_sys_reset_req || sec_reset_req || tru_reset_req || emu_reset_req
                   || (mode == RPMCO_FULL_ON && hibernate_req)
                   || (pll_was_locked && !pll_locked_s);

  always_ff @(posedge clk) begin
    if (hw_clr) begin
      pll_was_locked <= 1'b0;
    end else begin
      pll_was_locked <= pll_locked_s;
    end
  end

  // hibernate state is kept through hardware reset only as the wake trigger below;
  // the regulator then restores core power and the whole chip boots
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hib_from_reset <= 1'b0;
    end else if (hw_rst_s && mode == RPMCO_HIBERNATE) begin
      hib_from_reset <= 1'b1;
    end else if (rst_state == RPMCO_WAKE && rst_cnt == `RPMCO_WAKE_SETTLE) begin
      hib_from_reset <= 1'b0;
    end
  end

  // system reset does not clear this controller: its state is only cleared by hw_clr
  always_ff @(posedge clk) begin
    if (hw_clr) begin
      sys_rst_pend <= 1'b0;
    end else if (sys_req) begin
      sys_rst_pend <= 1'b1;
    end else if (rst_state == RPMCO_SYS_RST) begin
      sys_rst_pend <= 1'b0;
    end
  end

  always_comb begin
    next_rst_state = rst_state;
    unique case (rst_state)
      RPMCO_RUN: begin
        if (hib_from_reset) begin
          next_rst_state = RPMCO_WAKE;
        end else if (sys_rst_pend) begin
          next_rst_state = RPMCO_SYS_RST;
        end else if (sw_core_reset_req) begin
          next_rst_state = RPMCO_CORE_RST;
        end
      end
      RPMCO_SYS_RST, RPMCO_CORE_RST: begin
        if (rst_cnt == `RPMCO_RST_PULSE) begin
          next_rst_state = RPMCO_RUN;
        end
      end
      RPMCO_WAKE: begin
        if (rst_cnt == `RPMCO_WAKE_SETTLE) begin
          next_rst_state = RPMCO_SYS_RST;
        end
      end
      default: begin
        next_rst_state = RPMCO_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rst_state <= RPMCO_RUN;
      rst_cnt <= 4'h0;
    end else if (hw_rst_s) begin
      rst_state <= RPMCO_RUN;
      rst_cnt <= 4'h0;
    end else begin
      rst_state <= next_rst_state;
      rst_cnt <= (next_rst_state != rst_state) ? 4'h0 : rst_cnt + 4'h1;
    end
  end

  // outputs: held in reset while hardware reset stands, then released to boot
  // a woken chip stays in reset from the pin through the boot pulse: no one-cycle gap
  always_ff @(posedge clk) begin
    if (hw_clr) begin
      system_reset_out <= 1'b1;
    end else begin
      system_reset_out <= (rst_state == RPMCO_SYS_RST) || (rst_state == RPMCO_WAKE)
                          || hib_from_reset;
    end
  end

  always_ff @(posedge clk) begin
    if (hw_clr) begin
      core_reset_out <= 1'b1;
    end else begin
      core_reset_out <= (rst_state != RPMCO_RUN) || hib_from_reset;
    end
  end

  // wake output high asks for core power; low only while hibernating
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      regulator_wake_out <= 1'b1;
    end else begin
      regulator_wake_out <= (mode != RPMCO_HIBERNATE) || hw_rst_s || hib_from_reset;
    end
  end

  // pins float only in a settled hibernate; a pending wake drives them again
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pins_tristate <= 1'b0;
    end else begin
      pins_tristate <= (mode == RPMCO_HIBERNATE) && !hw_rst_s && !hib_from_reset;
    end
  end

  // =====================================================
  // clock output divider and select, glitch-free except when switching into a ratio-1 source
  // =====================================================
  // dividers count rising edges of the chosen (synchronised) level; a ratio of n
  // toggles the output every n/2 source edges (rounded down), so the observed clock is src/n for even n, src/(n-1) for odd n>1
  function automatic logic [7:0] rpmco_ratio(input logic [2:0] sel, input logic [7:0] prog);
    unique case (sel)
      `RPMCO_SRC_CORE: rpmco_ratio = `RPMCO_DIV_CORE;
      `RPMCO_SRC_SYS: rpmco_ratio = `RPMCO_DIV_SYS;
      `RPMCO_SRC_PERIPH: rpmco_ratio = `RPMCO_DIV_PERIPH;
      `RPMCO_SRC_CRYPTO: rpmco_ratio = `RPMCO_DIV_CRYPTO;
      `RPMCO_SRC_DRAM: rpmco_ratio = `RPMCO_DIV_DRAM;
      `RPMCO_SRC_OUTCLK: rpmco_ratio = (prog == 8'h00) ? 8'h01 : prog;
      default: rpmco_ratio = 8'h00; // buffer path: no divider
    endcase
  endfunction

  function automatic logic rpmco_level(input logic [2:0] sel, input logic [5:0] lv, input logic b);
    unique case (sel)
      `RPMCO_SRC_CORE: rpmco_level = lv[5];
      `RPMCO_SRC_SYS: rpmco_level = lv[4];
      `RPMCO_SRC_PERIPH: rpmco_level = lv[3];
      `RPMCO_SRC_CRYPTO: rpmco_level = lv[2];
      `RPMCO_SRC_DRAM: rpmco_level = lv[1];
      `RPMCO_SRC_OUTCLK: rpmco_level = lv[0];
      default: rpmco_level = b;
    endcase
  endfunction

  logic [2:0] cur_sel;
  logic [7:0] cur_ratio;
  logic src_prev;
  logic [7:0] div_cnt;
  logic div_out;
  logic src_now;
  logic src_rise;
  logic [7:0] period_cnt;
  assign src_now = rpmco_level(cur_sel, clk_lv, buf_s);
  assign src_rise = src_now && !src_prev;
  // half period of the divided clock in source edges: ratio/2 for n>1, direct for 1
  assign period_cnt = (cur_ratio > 8'h01) ? (cur_ratio >> 1) : 8'h01;
  // level the pin shows one clk later; a switch is taken only while it is low
  logic out_lv;
  logic [7:0] want_ratio;
  logic sel_change;
  logic sel_ok;
  assign out_lv = (cur_ratio == 8'h00) ? buf_s : div_out;
  assign want_ratio = rpmco_ratio(clkout_sel, outclk_div);
  // a new programmable ratio on the current source counts as a change too
  assign sel_change = (clkout_sel != cur_sel) || (want_ratio != cur_ratio);
  // the buffer path has no divider that starts low, so its own level must be low as well
  assign sel_ok = sel_change && !out_lv && (cur_ratio == 8'h00 || div_cnt == 8'h00)
                  && (want_ratio != 8'h00 || !buf_s);

  always_ff @(posedge clk) begin
    if (hw_clr) begin
      cur_sel <= `RPMCO_RST_SRC;
      cur_ratio <= 8'h00;
      src_prev <= 1'b0;
      div_cnt <= 8'h00;
      div_out <= 1'b0;
    end else begin
      src_prev <= src_now;
      // a new source is taken only while the output is low at a period end: no runt unless the new ratio is 1
      if (sel_ok) begin
        cur_sel <= clkout_sel;
        cur_ratio <= want_ratio;
        div_cnt <= 8'h00;
        // seed the edge detector from the new source so no false rise is counted
        src_prev <= rpmco_level(clkout_sel, clk_lv, buf_s);
      end else if (cur_ratio == 8'h01) begin
        div_out <= src_now;
      end else if (cur_ratio != 8'h00 && src_rise) begin
        if (div_cnt + 8'h01 >= period_cnt) begin
          div_cnt <= 8'h00;
          div_out <= !div_out;
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (hw_clr) begin
      clock_output_pin <= 1'b0;
    end else begin
      clock_output_pin <= out_lv;
    end
  end
endmodule

// ===== include/rpmco_defs.svh
`ifndef RPMCO_DEFS_SVH
`define RPMCO_DEFS_SVH
// clock-output source codes
`define RPMCO_SRC_BUF 3'h0
`define RPMCO_SRC_CORE 3'h1
`define RPMCO_SRC_SYS 3'h2
`define RPMCO_SRC_PERIPH 3'h3
`define RPMCO_SRC_CRYPTO 3'h4
`define RPMCO_SRC_DRAM 3'h5
`define RPMCO_SRC_OUTCLK 3'h6
// divide ratios as full-period counts of source edges
`define RPMCO_DIV_CORE 8'h10
`define RPMCO_DIV_SYS 8'h08
`define RPMCO_DIV_PERIPH 8'h01
`define RPMCO_DIV_CRYPTO 8'h08
`define RPMCO_DIV_DRAM 8'h08
// reset values
`define RPMCO_RST_SRC 3'h0
`define RPMCO_RST_DIV 8'h01
// last count of a generated reset pulse; the pulse lasts one cycle more
`define RPMCO_RST_PULSE 4'h8
// last count of the wake settle before the boot reset pulse; the settle lasts one cycle more
`define RPMCO_WAKE_SETTLE 4'hf
`endif

// ===== include/rpmco_pkg.sv
package rpmco_pkg;
  typedef enum logic [2:0] {
    RPMCO_FULL_ON = 3'b001,
    RPMCO_DEEP_SLEEP = 3'b010,
    RPMCO_HIBERNATE = 3'b100
  } rpmco_mode_e;
  typedef enum logic [3:0] {
    RPMCO_RUN = 4'b0001,
    RPMCO_SYS_RST = 4'b0010,
    RPMCO_CORE_RST = 4'b0100,
    RPMCO_WAKE = 4'b1000
  } rpmco_rst_e;
  // internal clocks sampled as levels (they are slow copies relative to clk here)
  typedef struct packed {
    logic core;
    logic sys;
    logic periph;
    logic crypto;
    logic dram;
    logic outclk;
  } rpmco_clks_s;
  // sources of a system reset
  typedef struct packed {
    logic sw;
    logic sec;
    logic trigger_routing_unit;
    logic emu;
    logic pll_fault;
  } rpmco_sysreq_s;
  // clock and power enables toward the chip
  typedef struct packed {
    logic pll_en;
    logic pll_bypass;
    logic core_clk_en;
    logic sync_clk_en;
    logic async_block;
    logic core_pwr;
  } rpmco_pwr_s;
endpackage

// ===== verif/rpmco_properties.sv
`timescale 1ns/1ns
// ==========
// power-mode and reset properties
module rpmco_properties
  import rpmco_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pll_locked,
  input wire logic sw_sys_reset_req,
  input wire logic sec_reset_req,
  input wire logic tru_reset_req,
  input wire logic emu_reset_req,
  input wire logic sw_core_reset_req,
  input wire logic regulator_wake_out,
  input wire logic system_reset_out,
  input wire logic core_reset_out,
  input wire logic pins_tristate,
  input wire rpmco_pwr_s pwr,
  input wire rpmco_mode_e mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic any_req;
  assign any_req = sw_sys_reset_req | sec_reset_req | tru_reset_req | emu_reset_req;
  sequence s_pulse_held;
    system_reset_out[*8];
  endsequence
  sequence s_core_asked;
    $past(sw_core_reset_req, 2) || $past(sw_core_reset_req, 3) || $past(sw_core_reset_req, 4);
  endsequence
  a_sys_req_reset: assert property ($rose(any_req) |-> ##[1:4] system_reset_out)
    else $error("system reset not raised");
  a_reset_pulse_len: assert property ($rose(system_reset_out) |-> s_pulse_held)
    else $error("system reset too short");
  a_pll_fault_reset: assert property ($fell(pll_locked) |-> ##[1:6] system_reset_out)
    else $error("lock loss gave no reset");
  a_core_only_sw: assert property ($rose(core_reset_out) && !system_reset_out |-> s_core_asked)
    else $error("core reset without request");
  a_full_on_pll: assert property (mode == RPMCO_FULL_ON && $past(mode) == RPMCO_FULL_ON
    |-> pwr.pll_en && !pwr.pll_bypass && pwr.core_pwr)
    else $error("full-on pll state wrong");
  a_deep_clk_off: assert property ($rose(mode == RPMCO_DEEP_SLEEP)
    |-> ##[0:1] (!pwr.pll_en && !pwr.core_clk_en && !pwr.sync_clk_en && pwr.core_pwr))
    else $error("deep sleep clocks on");
  a_hib_power_off: assert property (mode == RPMCO_HIBERNATE && !regulator_wake_out && !system_reset_out
    |-> !pwr.core_pwr && !pwr.core_clk_en)
    else $error("hibernate left power on");
  a_wake_drop_hib: assert property ($fell(regulator_wake_out) |-> mode == RPMCO_HIBERNATE)
    else $error("wake dropped outside hibernate");
  a_tristate_hib: assert property ($rose(pins_tristate) |-> mode == RPMCO_HIBERNATE)
    else $error("pins released outside hibernate");
  a_wake_reboot: assert property ($rose(regulator_wake_out) |-> ##[0:60] system_reset_out)
    else $error("wake without boot reset");
endmodule

// ===== verif/rpmco_reg_model.sv
`timescale 1ns/1ns
// ==========
// regulator and reset-pin model
module rpmco_reg_model (
  input wire logic clk,
  input wire logic wake_req,
  input wire logic regulator_wake_out,
  output logic hardware_reset_in_n,
  output logic supply_on
);
  logic [3:0] low_cnt = 4'h0;
  always_ff @(posedge clk) begin
    supply_on <= regulator_wake_out;
  end
  // burst outlasts the two-flop synchroniser with margin
  always_ff @(posedge clk) begin
    if (wake_req) begin
      low_cnt <= 4'h6;
    end else if (low_cnt != 4'h0) begin
      low_cnt <= low_cnt - 4'h1;
    end
  end
  assign hardware_reset_in_n = (low_cnt == 4'h0);
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ns
// ==========
// bench
module tb_top;
  import rpmco_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic src = 1'b0;
  logic [2:0] clkout_sel = 3'h0;
  logic [7:0] outclk_div = 8'h04;
  logic [3:0] sreq = 4'h0;
  logic core_req = 1'b0;
  logic pll_locked = 1'b1;
  logic ds_req = 1'b0;
  logic hib_req = 1'b0;
  logic wake_event = 1'b0;
  logic wake_req = 1'b0;
  logic hw_n, pin, wake, sys_rst, core_rst, tri_st, supply;
  rpmco_pwr_s pwr;
  rpmco_mode_e mode;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  // slow source: one period per 8 clk, all clock inputs share it
  always begin
    repeat (4) @(posedge clk);
    #5 src = ~src;
  end
  rpmco_reg_model u_reg (.clk, .wake_req, .regulator_wake_out(wake), .hardware_reset_in_n(hw_n),
    .supply_on(supply));
  rpmco_top u_dut (.clk, .rst_b, .hardware_reset_in_n(hw_n), .input_clock_buffer(src),
    .clks({6{src}}), .clkout_sel, .outclk_div, .sw_sys_reset_req(sreq[3]), .sw_core_reset_req(core_req),
    .sec_reset_req(sreq[2]), .tru_reset_req(sreq[1]), .emu_reset_req(sreq[0]), .pll_locked,
    .deep_sleep_req(ds_req), .hibernate_req(hib_req), .wake_event, .clock_output_pin(pin),
    .regulator_wake_out(wake), .system_reset_out(sys_rst), .core_reset_out(core_rst),
    .pins_tristate(tri_st), .pwr, .mode);
  task automatic close_out;
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [7:0] want, input logic [7:0] got);
    n_tests++;
    if (got !== want) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, want, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic wait_rst(input logic val, input int lim, output int k);
    k = 0;
    while (sys_rst !== val && k < lim) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic t_clkout;
    logic [7:0] want [7] = '{8'h40, 8'h04, 8'h08, 8'h40, 8'h08, 8'h08, 8'h10};
    logic prev;
    int r;
    for (int s = 0; s < 7; s++) begin
      clkout_sel = 3'(s);
      cyc(300);
      r = 0;
      repeat (512) begin
        prev = pin;
        cyc(1);
        if (pin === 1'b1 && prev === 1'b0) r++;
      end
      chk("clkout rises", want[s], (r >= want[s] - 1 && r <= want[s] + 1) ? want[s] : 8'(r));
    end
    clkout_sel = 3'h0;
  endtask
  task automatic t_sys_src;
    int k;
    for (int i = 0; i < 4; i++) begin
      sreq = 4'h8 >> i;
      cyc(1);
      sreq = 4'h0;
      wait_rst(1'b1, 8, k);
      chk("sys reset", 8'h01, 8'(sys_rst));
      chk("core in sys reset", 8'h01, 8'(core_rst));
      wait_rst(1'b0, 20, k);
      chk("sys reset length", 8'h09, 8'(k));
      cyc(3);
    end
  endtask
  task automatic t_faults;
    int k;
    pll_locked = 1'b0;
    wait_rst(1'b1, 8, k);
    chk("pll fault reset", 8'h01, 8'(sys_rst));
    pll_locked = 1'b1;
    wait_rst(1'b0, 20, k);
    cyc(4);
    core_req = 1'b1;
    cyc(1);
    core_req = 1'b0;
    cyc(4);
    chk("core reset", 8'h01, 8'(core_rst));
    chk("no sys reset", 8'h00, 8'(sys_rst));
    cyc(12);
  endtask
  task automatic t_modes;
    ds_req = 1'b1;
    cyc(1);
    ds_req = 1'b0;
    cyc(4);
    chk("deep mode", 8'(RPMCO_DEEP_SLEEP), 8'(mode));
    chk("deep pwr", 8'h03, 8'({pwr.pll_en, pwr.core_clk_en, pwr.sync_clk_en, pwr.async_block, pwr.core_pwr}));
    wake_event = 1'b1;
    cyc(1);
    wake_event = 1'b0;
    cyc(6);
    chk("full-on mode", 8'(RPMCO_FULL_ON), 8'(mode));
    hib_req = 1'b1;
    cyc(1);
    hib_req = 1'b0;
    cyc(20);
    chk("hib mode", 8'(RPMCO_HIBERNATE), 8'(mode));
    chk("hib wake", 8'h00, 8'({wake, supply, pwr.core_pwr}));
    chk("hib tristate", 8'h01, 8'(tri_st));
    wake_req = 1'b1;
    cyc(1);
    wake_req = 1'b0;
    cyc(5);
    chk("wake raised", 8'h01, 8'(wake));
    cyc(45);
    chk("booted", 8'h07, 8'({sys_rst, tri_st, supply, wake, mode == RPMCO_FULL_ON}));
  endtask
  initial begin
    cyc(12);
    rst_b = 1'b1;
    cyc(3);
    chk("reset mode", 8'(RPMCO_FULL_ON), 8'(mode));
    chk("reset pwr", 8'h2d, 8'(pwr));
    chk("reset outs", 8'h02, 8'({sys_rst, core_rst, wake, tri_st}));
    t_clkout();
    t_sys_src();
    t_faults();
    t_modes();
    close_out();
  end
endmodule
bind rpmco_top rpmco_properties u_props (.clk, .rst_b, .pll_locked, .sw_sys_reset_req, .sec_reset_req,
  .tru_reset_req, .emu_reset_req, .sw_core_reset_req, .regulator_wake_out, .system_reset_out,
  .core_reset_out, .pins_tristate, .pwr, .mode);
